// file: rtl/encoder_frequency_measure.sv
/*
 * Two-channel pulse frequency measurement with minimum window,
 * zero-frequency timeout and base-channel selection, plus a
 * classic Wishbone register slave.
 * Assumes pulse inputs already synchronous to clk_sys.
 */
// Implementation choices: the address map and register access over Wishbone.
`timescale 1ns/10ps

// Summary of operation
// - Each measurement window on both channels lasts at least the programmed sampling time (1 ms to 9999 ms, default 1 ms).
// - The sampling time acts as a smoothing filter, so a longer setting lengthens the result response time.
// - The gap between consecutive rising edges on each channel is timed against one shared zero timeout.
// - A channel reads exactly 0 Hz once its edge gap exceeds the timeout (10 ms to 9999 ms, default 100 ms).
// - The base-select setting picks sensor 1 (value 0) or sensor 2 (value 1) as base frequency, default 0.
// - Only the selected base frequency drives the analogue, control and relay evaluation output.
// - In the single-encoder variant both base-select values and both splitter-source values behave the same.
// - In the single-encoder variant any drift-fault clear acts as the combined clear for both channels.
module encoder_frequency_measure
   import freq_measure_pkg::*;
(
   input  wire logic              clk_sys,
   input  wire logic              arst_n,
   input  wire logic              ce,
   input  wire logic              wb_cyc_i,
   input  wire logic              wb_stb_i,
   input  wire logic              wb_we_i,
   input  wire logic [7:0]        wb_adr_i,
   input  wire logic [3:0]        wb_sel_i,
   input  wire logic [31:0]       wb_dat_i,
   output logic      [31:0]       wb_dat_o,
   output logic                   wb_ack_o,
   input  wire logic [1:0]        pulse_in,
   output logic      [FREQ_W-1:0] base_freq,
   output logic                   base_is_zero,
   output logic                   splitter_source,
   output logic      [1:0]        drift_clear
);

   ////////////////////////////////////////////////////////////////////////////
   // Bus slave and configuration
   logic             ack_reg,     ack_next;
   logic [31:0]      rdata_reg,   rdata_next;
   logic [13:0]      sample_ms_reg, sample_ms_next;
   logic [13:0]      wait_ms_reg,   wait_ms_next;
   logic [2:0]       config_reg,  config_next;
   logic [1:0]       clear_reg,   clear_next;
   logic [CYC_W-1:0] samp_cyc_reg, samp_cyc_next;
   logic [CYC_W-1:0] wait_cyc_reg, wait_cyc_next;
   logic             wr_take;
   logic [13:0]      wr_time;
   logic             single_var;

   logic [FREQ_W-1:0] freq_reg [2];
   logic [1:0]        zero_flag;
   logic [1:0]        busy_flag;
   logic              base_sel_eff;
   logic [FREQ_W-1:0] base_reg,  base_next;
   logic              bzero_reg, bzero_next;
   logic              split_reg, split_next;

   assign wr_take    = wb_cyc_i & wb_stb_i & wb_we_i & ack_reg;
   assign single_var = config_reg[CFG_SINGLE_BIT];

   always_comb begin
      ack_next      = 1'b0;
      rdata_next    = rdata_reg;
      sample_ms_next = sample_ms_reg;
      wait_ms_next  = wait_ms_reg;
      config_next   = config_reg;
      clear_next    = 2'b00;
      wr_time       = 14'h0000;
      if (wb_cyc_i && wb_stb_i && !ack_reg) begin
         ack_next = 1'b1;
         case (wb_adr_i)
            ADDR_SAMPLE: rdata_next = {18'h0_0000, sample_ms_reg};
            ADDR_WAIT:   rdata_next = {18'h0_0000, wait_ms_reg};
            ADDR_CONFIG: rdata_next = {29'h0000_0000, config_reg};
            ADDR_FREQ1:  rdata_next = freq_reg[0];
            ADDR_FREQ2:  rdata_next = freq_reg[1];
            ADDR_BASE:   rdata_next = base_reg;
            ADDR_STATUS: rdata_next = {28'h000_0000, busy_flag, zero_flag};
            default:     rdata_next = 32'h0000_0000;
         endcase
      end
      if (wr_take) begin
         case (wb_adr_i)
            ADDR_SAMPLE: begin
               wr_time[7:0]  = wb_sel_i[0] ? wb_dat_i[7:0] : sample_ms_reg[7:0];
               wr_time[13:8] = wb_sel_i[1] ? wb_dat_i[13:8] : sample_ms_reg[13:8];
               if (wr_time < SAMPLE_MS_MIN) begin
                  sample_ms_next = SAMPLE_MS_MIN;
               end else if (wr_time > SAMPLE_MS_MAX) begin
                  sample_ms_next = SAMPLE_MS_MAX;
               end else begin
                  sample_ms_next = wr_time;
               end
            end
            ADDR_WAIT: begin
               wr_time[7:0]  = wb_sel_i[0] ? wb_dat_i[7:0] : wait_ms_reg[7:0];
               wr_time[13:8] = wb_sel_i[1] ? wb_dat_i[13:8] : wait_ms_reg[13:8];
               if (wr_time < WAIT_MS_MIN) begin
                  wait_ms_next = WAIT_MS_MIN;
               end else if (wr_time > WAIT_MS_MAX) begin
                  wait_ms_next = WAIT_MS_MAX;
               end else begin
                  wait_ms_next = wr_time;
               end
            end
            ADDR_CONFIG: begin
               if (wb_sel_i[0]) begin
                  config_next = wb_dat_i[2:0];
               end
            end
            ADDR_CLEAR: begin
               if (wb_sel_i[0]) begin
                  // Per-channel clear widened to combined in single variant
                  if (wb_dat_i[CLR_BOTH_BIT] ||
                      (single_var && (wb_dat_i[CLR_CH1_BIT] || wb_dat_i[CLR_CH2_BIT]))) begin
                     clear_next = 2'b11;
                  end else begin
                     clear_next = {wb_dat_i[CLR_CH2_BIT], wb_dat_i[CLR_CH1_BIT]};
                  end
               end
            end
            default: begin
               clear_next = 2'b00;
            end
         endcase
      end
      // Converted once here so the channels only compare
      samp_cyc_next = CYC_W'(sample_ms_reg * CYCLES_PER_MS);
      wait_cyc_next = CYC_W'(wait_ms_reg * CYCLES_PER_MS);
   end

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         ack_reg       <= 1'b0;
         rdata_reg     <= 32'h0000_0000;
         sample_ms_reg <= SAMPLE_MS_DEFAULT;
         wait_ms_reg   <= WAIT_MS_DEFAULT;
         config_reg    <= CONFIG_RESET;
         clear_reg     <= 2'b00;
         samp_cyc_reg  <= CYC_W'(SAMPLE_MS_DEFAULT * CYCLES_PER_MS);
         wait_cyc_reg  <= CYC_W'(WAIT_MS_DEFAULT * CYCLES_PER_MS);
      end else if (ce) begin
         ack_reg       <= ack_next;
         rdata_reg     <= rdata_next;
         sample_ms_reg <= sample_ms_next;
         wait_ms_reg   <= wait_ms_next;
         config_reg    <= config_next;
         clear_reg     <= clear_next;
         samp_cyc_reg  <= samp_cyc_next;
         wait_cyc_reg  <= wait_cyc_next;
      end
   end

   assign wb_ack_o    = ack_reg;
   assign wb_dat_o    = rdata_reg;
   assign drift_clear = clear_reg;

   ////////////////////////////////////////////////////////////////////////////
   // Per-channel measurement and divider
   logic [1:0] pulse_d_reg;
   logic [1:0] rise;

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         pulse_d_reg <= 2'b00;
      end else if (ce) begin
         pulse_d_reg <= pulse_in;
      end
   end

   assign rise = pulse_in & ~pulse_d_reg;

   generate
      for (genvar ch = 0; ch < 2; ch++) begin : g_ch
         ch_state_e         state_reg,   state_next;
         logic [CYC_W-1:0]  elapsed_reg, elapsed_next;
         logic [CYC_W-1:0]  period_reg,  period_next;
         logic [EDGE_W-1:0] edges_reg,   edges_next;
         logic              zero_reg,    zero_next;
         logic              busy_reg,    busy_next;
         logic [CYC_W:0]    rem_reg,     rem_next;
         logic [NUM_W-1:0]  quo_reg,     quo_next;
         logic [CYC_W-1:0]  den_reg,     den_next;
         logic [STEP_W-1:0] step_reg,    step_next;
         logic [FREQ_W-1:0] fout_reg,    fout_next;
         logic [CYC_W-1:0]  elapsed_inc;
         logic [CYC_W-1:0]  period_inc;
         logic [CYC_W:0]    rem_sh;
         logic [NUM_W-1:0]  quo_sh;

         always_comb begin
            state_next   = state_reg;
            elapsed_next = elapsed_reg;
            period_next  = period_reg;
            edges_next   = edges_reg;
            zero_next    = zero_reg;
            busy_next    = busy_reg;
            rem_next     = rem_reg;
            quo_next     = quo_reg;
            den_next     = den_reg;
            step_next    = step_reg;
            fout_next    = fout_reg;
            elapsed_inc  = (&elapsed_reg) ? elapsed_reg : elapsed_reg + 1'b1;
            period_inc   = (&period_reg) ? period_reg : period_reg + 1'b1;
            rem_sh       = {rem_reg[CYC_W-1:0], quo_reg[NUM_W-1]};
            quo_sh       = {quo_reg[NUM_W-2:0], 1'b0};

            // Restoring division, one quotient bit per cycle
            if (busy_reg) begin
               if (rem_sh >= {1'b0, den_reg}) begin
                  rem_next = rem_sh - {1'b0, den_reg};
                  quo_next = quo_sh | {{(NUM_W-1){1'b0}}, 1'b1};
               end else begin
                  rem_next = rem_sh;
                  quo_next = quo_sh;
               end
               step_next = step_reg - 1'b1;
               if (step_reg == {{(STEP_W-1){1'b0}}, 1'b1}) begin
                  busy_next = 1'b0;
                  zero_next = 1'b0;
                  // Saturate rather than wrap on absurd rates
                  fout_next = (|quo_next[NUM_W-1:FREQ_W]) ? {FREQ_W{1'b1}} : quo_next[FREQ_W-1:0];
               end
            end

            period_next = rise[ch] ? {CYC_W{1'b0}} : period_inc;
            case (state_reg)
               CH_WAIT_EDGE: begin
                  if (rise[ch]) begin
                     state_next   = CH_MEASURE;
                     elapsed_next = {CYC_W{1'b0}};
                     edges_next   = {EDGE_W{1'b0}};
                  end
               end
               CH_MEASURE: begin
                  elapsed_next = elapsed_inc;
                  if (period_inc > wait_cyc_reg) begin
                     state_next = CH_WAIT_EDGE;
                     zero_next  = 1'b1;
                     busy_next  = 1'b0;
                     fout_next  = {FREQ_W{1'b0}};
                  end else if (rise[ch]) begin
                     if (elapsed_inc >= samp_cyc_reg) begin
                        // Window closes on this edge; next one opens here
                        rem_next     = {(CYC_W+1){1'b0}};
                        // Widened first: edges times scale overflows the counter width
                        quo_next     = (NUM_W'(edges_reg) + NUM_W'(1)) * NUM_W'(FREQ_SCALE);
                        den_next     = elapsed_inc;
                        step_next    = DIV_STEPS;
                        busy_next    = 1'b1;
                        elapsed_next = {CYC_W{1'b0}};
                        edges_next   = {EDGE_W{1'b0}};
                     end else if (!(&edges_reg)) begin
                        edges_next = edges_reg + 1'b1;
                     end
                  end
               end
               default: begin
                  state_next = CH_WAIT_EDGE;
               end
            endcase
         end

         always_ff @(posedge clk_sys or negedge arst_n) begin
            if (!arst_n) begin
               state_reg   <= CH_WAIT_EDGE;
               elapsed_reg <= {CYC_W{1'b0}};
               period_reg  <= {CYC_W{1'b0}};
               edges_reg   <= {EDGE_W{1'b0}};
               zero_reg    <= 1'b1;
               busy_reg    <= 1'b0;
               rem_reg     <= {(CYC_W+1){1'b0}};
               quo_reg     <= {NUM_W{1'b0}};
               den_reg     <= {CYC_W{1'b0}};
               step_reg    <= {STEP_W{1'b0}};
               fout_reg    <= {FREQ_W{1'b0}};
            end else if (ce) begin
               state_reg   <= state_next;
               elapsed_reg <= elapsed_next;
               period_reg  <= period_next;
               edges_reg   <= edges_next;
               zero_reg    <= zero_next;
               busy_reg    <= busy_next;
               rem_reg     <= rem_next;
               quo_reg     <= quo_next;
               den_reg     <= den_next;
               step_reg    <= step_next;
               fout_reg    <= fout_next;
            end
         end

         assign freq_reg[ch]  = fout_reg;
         assign zero_flag[ch] = zero_reg;
         assign busy_flag[ch] = busy_reg;
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // Base frequency selection
   // Single variant has one real sensor, so selection cannot matter
   assign base_sel_eff = single_var ? 1'b0 : config_reg[CFG_BASE_SEL_BIT];

   always_comb begin
      base_next  = base_sel_eff ? freq_reg[1] : freq_reg[0];
      bzero_next = base_sel_eff ? zero_flag[1] : zero_flag[0];
      split_next = single_var ? 1'b0 : config_reg[CFG_SPLIT_SEL_BIT];
   end

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         base_reg  <= {FREQ_W{1'b0}};
         bzero_reg <= 1'b1;
         split_reg <= 1'b0;
      end else if (ce) begin
         base_reg  <= base_next;
         bzero_reg <= bzero_next;
         split_reg <= split_next;
      end
   end

   assign base_freq       = base_reg;
   assign base_is_zero    = bzero_reg;
   assign splitter_source = split_reg;

endmodule : encoder_frequency_measure

// file: shared/freq_measure_pkg.sv
/*
 * Constants, register map and state types for the two-channel
 * encoder frequency measurement block.
 * Assumes a 20 MHz system clock and a 32-bit classic Wishbone bus.
 */
package freq_measure_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Clock and time base
   localparam int CLK_HZ        = 20_000_000;
   localparam int MS_PER_S      = 1000;
   localparam int CYCLES_PER_MS = CLK_HZ / MS_PER_S;

   // Times are held in milliseconds
   localparam logic [13:0] SAMPLE_MS_MIN     = 14'h0001;
   localparam logic [13:0] SAMPLE_MS_MAX     = 14'h270F;
   localparam logic [13:0] SAMPLE_MS_DEFAULT = 14'h0001;
   localparam logic [13:0] WAIT_MS_MIN       = 14'h000A;
   localparam logic [13:0] WAIT_MS_MAX       = 14'h270F;
   localparam logic [13:0] WAIT_MS_DEFAULT   = 14'h0064;

   ////////////////////////////////////////////////////////////////////////////
   // Widths and scaling
   localparam int CYC_W  = 28;
   localparam int EDGE_W = 24;
   localparam int NUM_W  = EDGE_W + CYC_W;
   localparam int FREQ_W = 32;
   localparam int STEP_W = 6;
   localparam int FREQ_UNITS_PER_HZ = 10;
   localparam logic [CYC_W-1:0]  FREQ_SCALE = CYC_W'(CLK_HZ * FREQ_UNITS_PER_HZ);
   localparam logic [STEP_W-1:0] DIV_STEPS  = STEP_W'(NUM_W);

   ////////////////////////////////////////////////////////////////////////////
   // Register map (byte addresses)
   localparam logic [7:0] ADDR_SAMPLE = 8'h00;
   localparam logic [7:0] ADDR_WAIT   = 8'h04;
   localparam logic [7:0] ADDR_CONFIG = 8'h08;
   localparam logic [7:0] ADDR_CLEAR  = 8'h0C;
   localparam logic [7:0] ADDR_FREQ1  = 8'h10;
   localparam logic [7:0] ADDR_FREQ2  = 8'h14;
   localparam logic [7:0] ADDR_BASE   = 8'h18;
   localparam logic [7:0] ADDR_STATUS = 8'h1C;

   localparam int CFG_BASE_SEL_BIT  = 0;
   localparam int CFG_SPLIT_SEL_BIT = 1;
   localparam int CFG_SINGLE_BIT    = 2;
   localparam logic [2:0] CONFIG_RESET = 3'h0;

   localparam int CLR_CH1_BIT  = 0;
   localparam int CLR_CH2_BIT  = 1;
   localparam int CLR_BOTH_BIT = 2;

   typedef enum logic [0:0] {
      CH_WAIT_EDGE = 1'b0,
      CH_MEASURE   = 1'b1
   } ch_state_e;

endpackage : freq_measure_pkg

// file: test/freq_measure_checker.sv
/* Port-level checker for encoder_frequency_measure.
   Assumes one clock domain; ce gates the config shadow like the block. */
`timescale 1ns/10ps
module freq_measure_checker
   import freq_measure_pkg::*;
(
   input wire logic              clk_sys,
   input wire logic              arst_n,
   input wire logic              ce,
   input wire logic              wb_cyc_i,
   input wire logic              wb_stb_i,
   input wire logic              wb_we_i,
   input wire logic [7:0]        wb_adr_i,
   input wire logic [3:0]        wb_sel_i,
   input wire logic [31:0]       wb_dat_i,
   input wire logic [31:0]       wb_dat_o,
   input wire logic              wb_ack_o,
   input wire logic [1:0]        pulse_in,
   input wire logic [FREQ_W-1:0] base_freq,
   input wire logic              base_is_zero,
   input wire logic              splitter_source,
   input wire logic [1:0]        drift_clear
);
   ////////////////////////////////////////
   // Shadow of CONFIG, aged so the output flops have settled
   logic [2:0] cfg_reg, cfg_next;
   logic [1:0] cfg_age_reg, cfg_age_next;
   logic       cfg_wr;
   always_comb begin
      cfg_wr = wb_ack_o && wb_cyc_i && wb_stb_i && wb_we_i && wb_sel_i[0] && ce && (wb_adr_i == ADDR_CONFIG);
      cfg_next = cfg_wr ? wb_dat_i[2:0] : cfg_reg;
      cfg_age_next = cfg_wr ? 2'h0 : ((cfg_age_reg == 2'h3) ? 2'h3 : cfg_age_reg + 2'h1);
   end
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         cfg_reg     <= CONFIG_RESET;
         cfg_age_reg <= 2'h3;
      end else begin
         cfg_reg     <= cfg_next;
         cfg_age_reg <= cfg_age_next;
      end
   end
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!arst_n);
   sequence s_req;
      wb_cyc_i && wb_stb_i && !wb_ack_o && ce;
   endsequence
   sequence s_ack_pulse;
      wb_ack_o ##1 !wb_ack_o;
   endsequence
   AST_ACK_LATENCY: assert property (s_req |=> s_ack_pulse)
      else $error("ack not a single pulse one cycle after request");
   AST_ACK_CAUSE: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
      else $error("ack without request");
   AST_DRIFT_PULSE: assert property (drift_clear != 2'b00 |-> $past(wb_ack_o && wb_we_i && (wb_adr_i == ADDR_CLEAR)) ##1 drift_clear == 2'b00)
      else $error("drift clear pulse wrong");
   AST_SINGLE_CLEAR: assert property (drift_clear != 2'b00 && cfg_reg[CFG_SINGLE_BIT] |-> drift_clear == 2'b11)
      else $error("single variant clear not combined");
   AST_ZERO_FREQ: assert property (base_is_zero && $past(base_is_zero) |-> base_freq == 32'h0000_0000)
      else $error("zero flag with nonzero frequency");
   AST_UNMAPPED: assert property (wb_ack_o && !wb_we_i && (wb_adr_i >= 8'h20 || wb_adr_i == ADDR_CLEAR) |-> wb_dat_o == 32'h0000_0000)
      else $error("unmapped read not zero");
   AST_SAMPLE_RANGE: assert property (wb_ack_o && !wb_we_i && wb_adr_i == ADDR_SAMPLE |-> wb_dat_o[31:14] == 18'h0_0000 && wb_dat_o[13:0] >= SAMPLE_MS_MIN && wb_dat_o[13:0] <= SAMPLE_MS_MAX)
      else $error("sampling time out of range");
   AST_WAIT_RANGE: assert property (wb_ack_o && !wb_we_i && wb_adr_i == ADDR_WAIT |-> wb_dat_o[31:14] == 18'h0_0000 && wb_dat_o[13:0] >= WAIT_MS_MIN && wb_dat_o[13:0] <= WAIT_MS_MAX)
      else $error("wait time out of range");
   AST_CONFIG_READ: assert property (wb_ack_o && !wb_we_i && wb_adr_i == ADDR_CONFIG |-> wb_dat_o[2:0] == cfg_reg)
      else $error("config readback differs");
   AST_SPLIT: assert property (cfg_age_reg == 2'h3 |-> splitter_source == (cfg_reg[CFG_SPLIT_SEL_BIT] && !cfg_reg[CFG_SINGLE_BIT]))
      else $error("splitter source wrong");
endmodule : freq_measure_checker

bind encoder_frequency_measure freq_measure_checker u_checker (
   .clk_sys(clk_sys), .arst_n(arst_n), .ce(ce), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
   .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
   .pulse_in(pulse_in), .base_freq(base_freq), .base_is_zero(base_is_zero),
   .splitter_source(splitter_source), .drift_clear(drift_clear)
);

// file: test/pulse_sensor_model.sv
/* Two pulse sensors with programmable period in clock cycles.
   Assumes periods change rarely; a period of zero keeps the line low. */
`timescale 1ns/10ps
module pulse_sensor_model (
   input wire logic        clk_sys,
   input wire logic        arst_n,
   input wire logic [15:0] period_a,
   input wire logic [15:0] period_b,
   output logic     [1:0]  pulse_in
);
   ////////////////////////////////////////
   logic [15:0] cnt_a_reg;
   logic [15:0] cnt_b_reg;
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         cnt_a_reg <= 16'h0000;
         cnt_b_reg <= 16'h0000;
         pulse_in  <= 2'b00;
      end else begin
         cnt_a_reg <= (cnt_a_reg + 16'h0001 >= period_a) ? 16'h0000 : cnt_a_reg + 16'h0001;
         cnt_b_reg <= (cnt_b_reg + 16'h0001 >= period_b) ? 16'h0000 : cnt_b_reg + 16'h0001;
         // Half duty keeps both levels far above one cycle
         // Both sensors alike: same edge sense, one pulse per count
         pulse_in[0] <= (period_a != 16'h0000) && (cnt_a_reg < period_a / 2);
         pulse_in[1] <= (period_b != 16'h0000) && (cnt_b_reg < period_b / 2);
      end
   end
endmodule : pulse_sensor_model

// file: test/tb.sv
/* Self-checking bench for encoder_frequency_measure.
   Assumes the pulse sensor model and the bound checker compile with it. */
`timescale 1ns/10ps
`define CHK(act, exp) begin n_tests++; if ((act) !== (exp)) begin bad_count++; \
   $display("MISMATCH t=%0t got=%h exp=%h", $time, (act), (exp)); end end
module tb
   import freq_measure_pkg::*;
();
   logic              clk_sys, arst_n, ce, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
   logic              base_is_zero, splitter_source;
   logic [7:0]        wb_adr_i;
   logic [3:0]        wb_sel_i;
   logic [31:0]       wb_dat_i, wb_dat_o;
   logic [1:0]        pulse_in, drift_clear;
   logic [FREQ_W-1:0] base_freq;
   logic [15:0]       period_a, period_b;
   int                bad_count, n_tests;
   encoder_frequency_measure dut (.clk_sys(clk_sys), .arst_n(arst_n), .ce(ce), .wb_cyc_i(wb_cyc_i),
      .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
      .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .pulse_in(pulse_in), .base_freq(base_freq),
      .base_is_zero(base_is_zero), .splitter_source(splitter_source), .drift_clear(drift_clear));
   pulse_sensor_model u_sensors (.clk_sys(clk_sys), .arst_n(arst_n), .period_a(period_a),
      .period_b(period_b), .pulse_in(pulse_in));
   ////////////////////////////////////////
   task automatic wb_xfer(input logic we, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
      @(posedge clk_sys);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i  <= we;
      wb_sel_i <= 4'hF;
      wb_adr_i <= a;
      wb_dat_i <= d;
      // Ends on ack; only the watchdog ends a wait that never sees one
      do begin
         @(posedge clk_sys);
      end while (wb_ack_o !== 1'b1);
      q = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_we_i  <= 1'b0;
   endtask : wb_xfer
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] q;
      wb_xfer(1'b0, a, 32'h0000_0000, q);
      `CHK(q, e)
   endtask : rd_chk
   task automatic test_reset();
      logic [31:0] q;
      `CHK(base_freq, 32'h0000_0000)
      `CHK(base_is_zero, 1'b1)
      rd_chk(ADDR_SAMPLE, 32'h0000_0001);
      rd_chk(ADDR_WAIT, 32'h0000_0064);
      rd_chk(ADDR_CONFIG, 32'h0000_0000);
      rd_chk(ADDR_STATUS, 32'h0000_0003);
      rd_chk(8'h20, 32'h0000_0000);
      wb_xfer(1'b1, ADDR_FREQ1, 32'h0000_BEEF, q);
      rd_chk(ADDR_FREQ1, 32'h0000_0000);
   endtask : test_reset
   task automatic test_freq();
      period_a <= 16'h03E8;
      period_b <= 16'h01F4;
      // One full window of 20000 cycles plus the divider latency
      repeat (25000) @(posedge clk_sys);
      rd_chk(ADDR_FREQ1, 32'h0003_0D40);
      rd_chk(ADDR_FREQ2, 32'h0006_1A80);
      rd_chk(ADDR_STATUS, 32'h0000_0000);
      `CHK(base_freq, 32'h0003_0D40)
      `CHK(base_is_zero, 1'b0)
   endtask : test_freq
   task automatic test_select();
      logic [31:0] q;
      for (int c = 0; c < 8; c++) begin
         wb_xfer(1'b1, ADDR_CONFIG, 32'(c), q);
         rd_chk(ADDR_CONFIG, 32'(c));
         repeat (4) @(posedge clk_sys);
         `CHK(base_freq, (c[0] && !c[2]) ? 32'h0006_1A80 : 32'h0003_0D40)
         `CHK(splitter_source, c[1] && !c[2])
         for (int k = 0; k < 3; k++) begin
            wb_xfer(1'b1, ADDR_CLEAR, 32'h0000_0001 << k, q);
            @(posedge clk_sys);
            `CHK(drift_clear, (c[2] || k == 2) ? 2'b11 : 2'(1 << k))
         end
      end
      rd_chk(ADDR_CLEAR, 32'h0000_0000);
   endtask : test_select
   task automatic test_clamp();
      logic [31:0] q;
      wb_xfer(1'b1, ADDR_SAMPLE, 32'h0000_0000, q);
      rd_chk(ADDR_SAMPLE, 32'h0000_0001);
      wb_xfer(1'b1, ADDR_SAMPLE, 32'h0000_3FFF, q);
      rd_chk(ADDR_SAMPLE, 32'h0000_270F);
      wb_xfer(1'b1, ADDR_WAIT, 32'h0000_0000, q);
      rd_chk(ADDR_WAIT, 32'h0000_000A);
   endtask : test_clamp
   task automatic test_freeze();
      logic [31:0] f;
      @(posedge clk_sys);
      f = base_freq;
      // Request made while frozen must wait for ce
      ce       <= 1'b0;
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i  <= 1'b0;
      wb_adr_i <= ADDR_CONFIG;
      repeat (3) @(posedge clk_sys);
      `CHK(wb_ack_o, 1'b0)
      ce <= 1'b1;
      do begin
         @(posedge clk_sys);
      end while (wb_ack_o !== 1'b1);
      `CHK(wb_dat_o, 32'h0000_0007)
      `CHK(base_freq, f)
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
   endtask : test_freeze
   task automatic complete_run();
      if (bad_count == 0 && n_tests > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : complete_run
   initial begin
      clk_sys = 1'b0;
      forever #25 clk_sys = ~clk_sys;
   end
   initial begin
      {arst_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} = '0;
      {ce, wb_sel_i, period_a, period_b, bad_count, n_tests} = {5'h1F, 32'h0, 64'h0};
      repeat (8) @(posedge clk_sys);
      arst_n <= 1'b1;
      test_reset();
      test_freq();
      test_select();
      test_clamp();
      test_freeze();
      complete_run();
   end
   initial begin
      repeat (60000) @(posedge clk_sys);
      bad_count++;
      complete_run();
   end
endmodule : tb
